// [logic/shifr_regs.sv]
// Interrupt flag, enable mask, word counter and buffer window registers behind an AXI4-Lite slave.
//
// Operation
// - Clear register is write-only; ones clear flags.
// - Clear bits exist at 23, 22, 10:0.
// - Bits 23:22,10:0 sticky; 21:11 follow hardware.
// - Enable register: bits 23:0 read-write, 31:24 reserved.
// - Counter loads length/4, rounded up, at start.
// - Counter decrements by one in each cycle with a buffer push or pop; a same-cycle push and pop count once. Here the count holds at zero instead.
// - Window spans 0x80 to 0xfc, one buffer.
// - Window write pushes transmit, read pops receive.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

module shifr_regs
(
  input  wire logic                           clk_sys,              // System clock, 40 MHz.
  input  wire logic                           rst_b,                // Asynchronous reset, active low.
  // AXI4-Lite write address channel.
  input  wire logic                           s_axi_awvalid,        // Write address valid.
  output logic                                s_axi_awready,        // Write address ready.
  input  wire logic [shifr_pkg::ADDR_W-1:0]   s_axi_awaddr,         // Write byte address.
  input  wire logic [2:0]                     s_axi_awprot,         // Protection, not used.
  // AXI4-Lite write data channel.
  input  wire logic                           s_axi_wvalid,         // Write data valid.
  output logic                                s_axi_wready,         // Write data ready.
  input  wire logic [shifr_pkg::DATA_W-1:0]   s_axi_wdata,          // Write data.
  input  wire logic [3:0]                     s_axi_wstrb,          // Byte strobes.
  // AXI4-Lite write response channel.
  output logic                                s_axi_bvalid,         // Write response valid.
  input  wire logic                           s_axi_bready,         // Write response ready.
  output logic      [1:0]                     s_axi_bresp,          // Write response code.
  // AXI4-Lite read address channel.
  input  wire logic                           s_axi_arvalid,        // Read address valid.
  output logic                                s_axi_arready,        // Read address ready.
  input  wire logic [shifr_pkg::ADDR_W-1:0]   s_axi_araddr,         // Read byte address.
  input  wire logic [2:0]                     s_axi_arprot,         // Protection, not used.
  // AXI4-Lite read data channel.
  output logic                                s_axi_rvalid,         // Read data valid.
  input  wire logic                           s_axi_rready,         // Read data ready.
  output logic      [shifr_pkg::DATA_W-1:0]   s_axi_rdata,          // Read data.
  output logic      [1:0]                     s_axi_rresp,          // Read response code.
  // Controller side.
  input  wire logic [shifr_pkg::FLAG_W-1:0]   flag_event,           // Sticky set pulses and level conditions.
  input  wire logic [shifr_pkg::LEN_W-1:0]    transfer_byte_length, // Programmed byte length.
  input  wire logic                           transfer_start_bit,   // Pulse on each start-bit write of one.
  input  wire logic [shifr_pkg::DATA_W-1:0]   rx_buffer_word,       // Head word of the receive buffer.
  output logic                                tx_push_reg,          // One-cycle push into transmit buffer.
  output logic      [shifr_pkg::DATA_W-1:0]   tx_word_reg,          // Word pushed with tx_push_reg.
  output logic                                rx_pop_reg,           // One-cycle pop from receive buffer.
  output logic      [shifr_pkg::FLAG_W-1:0]   status_flags,         // Status flags, registered.
  output logic      [shifr_pkg::COUNT_W-1:0]  words_remaining,      // Buffer word counter, registered.
  output logic                                irq_reg               // Controller interrupt request.
);

  // ---------------------------------------------------------------------------
  // Write channel holding registers
  // ---------------------------------------------------------------------------
  logic                         aw_full_reg;   // A write address is held.
  logic [shifr_pkg::ADDR_W-1:0] aw_addr_reg;   // Held write address.
  logic                         w_full_reg;    // Write data is held.
  logic [shifr_pkg::DATA_W-1:0] w_data_reg;    // Held write data.
  logic [3:0]                   w_strb_reg;    // Held byte strobes.
  logic                         bvalid_reg;    // Write response pending.
  logic [1:0]                   bresp_reg;     // Pending write response code.
  logic                         awready_reg;   // Registered address ready.
  logic                         wready_reg;    // Registered data ready.

  // Address and data are taken independently, in either order.
  wire logic aw_take  = s_axi_awvalid && awready_reg;
  wire logic w_take   = s_axi_wvalid && wready_reg;
  // The write acts once both halves are held and the last response is gone.
  wire logic do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  wire logic aw_full_next = (aw_full_reg && !do_write) || aw_take;
  wire logic w_full_next  = (w_full_reg && !do_write) || w_take;
  wire logic bvalid_next  = do_write || (bvalid_reg && !s_axi_bready);

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  // Partial or misaligned writes are refused with an error and change nothing.
  wire logic wr_whole   = (w_strb_reg == shifr_pkg::FULL_STROBE) && (aw_addr_reg[1:0] == 2'h0);
  wire logic wr_clear   = wr_whole && (aw_addr_reg == shifr_pkg::OFS_FLAG_CLEAR);
  wire logic wr_enable  = wr_whole && (aw_addr_reg == shifr_pkg::OFS_ENABLE_MASK);
  wire logic wr_counter = wr_whole && (aw_addr_reg == shifr_pkg::OFS_WORD_COUNTER);
  // Every aligned word from the first to the last entry reaches the same buffer.
  wire logic wr_window  = wr_whole && (aw_addr_reg >= shifr_pkg::OFS_WINDOW_FIRST) &&
                          (aw_addr_reg <= shifr_pkg::OFS_WINDOW_LAST);
  wire logic wr_hit     = wr_clear || wr_enable || wr_counter || wr_window;
  wire logic [1:0] wr_resp = wr_hit ? shifr_pkg::RESP_OKAY : shifr_pkg::RESP_SLVERR;

  // Clear pulses reach only implemented sticky bits; zeros and reserved bits do nothing.
  wire logic [shifr_pkg::FLAG_W-1:0] clear_pulse =
    (do_write && wr_clear) ? (w_data_reg[23:0] & shifr_pkg::STICKY_MASK) : '0;

  // Write channel state.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= bvalid_next;
      awready_reg <= !aw_full_next;
      wready_reg  <= !w_full_next;
    end
  end

  // Payload capture; the full flags guard these, and the reset only keeps them defined.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= 4'h0;
      bresp_reg   <= shifr_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
        bresp_reg <= wr_resp;
    end
  end

  // ---------------------------------------------------------------------------
  // Enable mask and transmit push
  // ---------------------------------------------------------------------------
  logic [shifr_pkg::FLAG_W-1:0] enable_reg;  // One enable per status flag.

  // Only bits 23:0 are stored, so reserved bits always read back as zero.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      enable_reg <= shifr_pkg::ENABLE_RESET;
    else if (do_write && wr_enable)
      enable_reg <= w_data_reg[23:0];
  end

  // A window write becomes a one-cycle push with its word.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_push_reg <= 1'b0;
      tx_word_reg <= '0;
    end
    else
    begin
      tx_push_reg <= do_write && wr_window;
      if (do_write && wr_window)
        tx_word_reg <= w_data_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  logic                         rvalid_reg;   // Read data pending.
  logic                         arready_reg;  // Registered read address ready.
  logic [shifr_pkg::DATA_W-1:0] rdata_reg;    // Read data.
  logic [1:0]                   rresp_reg;    // Read response code.

  wire logic ar_take     = s_axi_arvalid && arready_reg;
  wire logic rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

  // Read decode, taken from the address on the bus at the taking edge.
  wire logic rd_align   = (s_axi_araddr[1:0] == 2'h0);
  wire logic rd_clear   = rd_align && (s_axi_araddr == shifr_pkg::OFS_FLAG_CLEAR);
  wire logic rd_enable  = rd_align && (s_axi_araddr == shifr_pkg::OFS_ENABLE_MASK);
  wire logic rd_counter = rd_align && (s_axi_araddr == shifr_pkg::OFS_WORD_COUNTER);
  wire logic rd_window  = rd_align && (s_axi_araddr >= shifr_pkg::OFS_WINDOW_FIRST) &&
                          (s_axi_araddr <= shifr_pkg::OFS_WINDOW_LAST);
  wire logic rd_hit     = rd_clear || rd_enable || rd_counter || rd_window;

  // The clear register is write only and reads as zero.
  wire logic [shifr_pkg::DATA_W-1:0] rd_value =
    rd_enable  ? {8'h00, enable_reg}      :
    rd_counter ? {8'h00, words_remaining} :
    rd_window  ? rx_buffer_word           :
                 32'h00000000;

  // Read channel state and data.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= shifr_pkg::RESP_OKAY;
      rx_pop_reg  <= 1'b0;
    end
    else
    begin
      rvalid_reg  <= rvalid_next;
      arready_reg <= !rvalid_next;
      rx_pop_reg  <= ar_take && rd_window;
      if (ar_take)
      begin
        rdata_reg <= rd_value;
        rresp_reg <= rd_hit ? shifr_pkg::RESP_OKAY : shifr_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Flags, counter and interrupt
  // ---------------------------------------------------------------------------
  logic [shifr_pkg::FLAG_W-1:0] flag_state;  // Flag bank output.

  // Sticky flags latch events; the others follow the controller directly.
  shifr_flag_bank
  #(
    .WIDTH  (shifr_pkg::FLAG_W),
    .STICKY (shifr_pkg::STICKY_MASK)
  )
  u_flags
  (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .flag_event (flag_event),
    .flag_clear (clear_pulse),
    .flag_state (flag_state)
  );

  // Each cycle with a window push or pop counts the remaining words down by one while above zero, even when both coincide.
  wire logic word_step = tx_push_reg || rx_pop_reg;

  // Reloads on every start pulse, whether or not a transfer was running.
  shifr_word_counter u_counter
  (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .load        (transfer_start_bit),
    .byte_length (transfer_byte_length),
    .word_step   (word_step),
    .count_reg   (words_remaining)
  );

  // The request is registered, so it lags the flag by one cycle.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flag_state & enable_reg);
  end

  // ---------------------------------------------------------------------------
  // Output wiring
  // ---------------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign status_flags  = flag_state;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // A write of one to the card interrupt bit of the clear register, with no event on that bit.
  sequence clear_write_s;
    do_write && wr_clear && w_data_reg[shifr_pkg::BIT_CARD_INT] && !flag_event[shifr_pkg::BIT_CARD_INT];
  endsequence

  clear_one_a: assert property (clear_write_s |=> !flag_state[shifr_pkg::BIT_CARD_INT])
    else $error("Card interrupt flag survived a clear write.");

  set_wins_a: assert property (flag_event[shifr_pkg::BIT_CMD_DONE] |=> flag_state[shifr_pkg::BIT_CMD_DONE])
    else $error("Completion flag event was lost.");

  sticky_hold_a: assert property ((flag_state[5] && !clear_pulse[5]) |=> flag_state[5])
    else $error("Sticky flag dropped without a clear.");

  level_follow_a: assert property ($past(rst_b) |-> flag_state[15] == $past(flag_event[15]))
    else $error("Level flag does not follow its condition.");

  zero_clear_a: assert property ((do_write && wr_clear && !w_data_reg[0] && flag_state[0]) |=> flag_state[0])
    else $error("Writing zero cleared a flag.");

  enable_store_a: assert property ((do_write && wr_enable) |=> enable_reg == $past(w_data_reg[23:0]))
    else $error("Enable mask did not take the written value.");

  irq_follow_a: assert property (irq_reg == |($past(flag_state) & $past(enable_reg)))
    else $error("Interrupt request disagrees with flags and enables.");

  counter_load_a: assert property (transfer_start_bit |=>
      words_remaining == ({1'b0, $past(transfer_byte_length[24:2])} + {23'h0, |$past(transfer_byte_length[1:0])}))
    else $error("Counter loaded a wrong word count.");

  counter_step_a: assert property ((word_step && !transfer_start_bit && words_remaining != 24'h0) |=>
      words_remaining == $past(words_remaining) - 24'h000001)
    else $error("Counter did not step down on a buffer access.");

  // A window write runs to its push one cycle after the write acts.
  sequence window_write_s;
    do_write && wr_window;
  endsequence

  window_push_a: assert property (window_write_s |=> tx_push_reg && tx_word_reg == $past(w_data_reg))
    else $error("Window write did not push its word.");

  window_pop_a: assert property ((ar_take && rd_window) |=> rx_pop_reg && rvalid_reg ##0 rdata_reg == $past(rx_buffer_word))
    else $error("Window read did not pop the receive word.");

endmodule : shifr_regs

// [shared/shifr_pkg.sv]
// Package of offsets, field layouts and reset values for the interrupt and buffer register bank.
package shifr_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;   // Byte address width; the bank spans 0x00 to 0xfc.
  localparam int unsigned DATA_W = 32;  // Data width of every register.

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAG_CLEAR   = 8'h38;  // Interrupt flag clear, write only.
  localparam logic [7:0] OFS_ENABLE_MASK  = 8'h3c;  // Interrupt enable mask, read-write.
  localparam logic [7:0] OFS_WORD_COUNTER = 8'h48;  // Buffer word counter, read only.
  localparam logic [7:0] OFS_WINDOW_FIRST = 8'h80;  // First entry of the buffer data window.
  localparam logic [7:0] OFS_WINDOW_LAST  = 8'hfc;  // Last entry of the buffer data window.

  // ---------------------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned FLAG_W         = 24;            // Status flags occupy bits 23:0.
  localparam logic [23:0] STICKY_MASK    = 24'hc007ff;    // Bits 23:22 and 10:0 latch until cleared.
  localparam int unsigned BIT_CMD_DONE   = 23;            // Command completion signal flag.
  localparam int unsigned BIT_CARD_INT   = 22;            // Card interrupt flag.
  localparam logic [23:0] ENABLE_RESET   = 24'h000000;    // Enable mask reset value.
  localparam int unsigned COUNT_W        = 24;            // Words remaining field, bits 23:0.
  localparam int unsigned LEN_W          = 25;            // Transfer byte length, bits 24:0.
  localparam logic [23:0] COUNT_RESET    = 24'h000000;    // Counter reset value.
  localparam logic [3:0]  FULL_STROBE    = 4'hf;          // Only whole-word writes are honoured.

  // ---------------------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Access completed.
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped, misaligned or partial access.

endpackage : shifr_pkg

// [logic/shifr_flag_bank.sv]
// Status flag bank: sticky or level-following flags with write-one-to-clear.
`timescale 1ns/1ps

module shifr_flag_bank
#(
  parameter int unsigned          WIDTH  = 24,            // Number of flags.
  parameter logic [WIDTH-1:0]     STICKY = '0             // One where a flag latches.
)
(
  input  wire logic             clk_sys,      // System clock.
  input  wire logic             rst_b,        // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] flag_event,   // Set pulses for sticky flags, levels otherwise.
  input  wire logic [WIDTH-1:0] flag_clear,   // One-cycle clear pulses, already masked.
  output logic      [WIDTH-1:0] flag_state    // Current flag values, registered.
);

  // ---------------------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------------------
  // A set arriving in the same cycle as a clear wins, so no event is lost.
  // Level flags follow their condition and ignore any clear request.
  wire logic [WIDTH-1:0] flag_next = (STICKY & ((flag_state & ~flag_clear) | flag_event)) |
                                     (~STICKY & flag_event);

  // The flag register itself.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      flag_state <= '0;
    else
      flag_state <= flag_next;
  end

endmodule : shifr_flag_bank

// [logic/shifr_word_counter.sv]
// Buffer word counter: loads the word count of a transfer and counts buffer accesses down.
`timescale 1ns/1ps

module shifr_word_counter
(
  input  wire logic                          clk_sys,      // System clock.
  input  wire logic                          rst_b,        // Asynchronous reset, active low.
  input  wire logic                          load,         // Transfer start pulse.
  input  wire logic [shifr_pkg::LEN_W-1:0]   byte_length,  // Transfer byte length.
  input  wire logic                          word_step,    // One buffer word moved.
  output logic      [shifr_pkg::COUNT_W-1:0] count_reg     // Words remaining.
);

  // ---------------------------------------------------------------------------
  // Next value
  // ---------------------------------------------------------------------------
  // A partial last word still takes a whole buffer word, hence the round up.
  wire logic                          partial_word = |byte_length[1:0];
  wire logic [shifr_pkg::COUNT_W-1:0] load_value   = {1'b0, byte_length[24:2]} +
                                                     {{(shifr_pkg::COUNT_W-1){1'b0}}, partial_word};
  // Stops at zero: extra accesses past the end must not wrap to a huge count.
  wire logic                          can_step     = word_step && (count_reg != '0);
  wire logic [shifr_pkg::COUNT_W-1:0] count_next   = load     ? load_value :
                                                     can_step ? count_reg - 24'h000001 :
                                                                count_reg;

  // The counter register; a start pulse overrides a same-cycle access.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      count_reg <= shifr_pkg::COUNT_RESET;
    else
      count_reg <= count_next;
  end

endmodule : shifr_word_counter

// [tb/shifr_rx_model.sv]
// Buffer model behind the data window: feeds receive words, keeps the last pushed word.
`timescale 1ns/1ps
module shifr_rx_model
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        rx_pop_reg,      // Pop strobe.
  input  wire logic        tx_push_reg,     // Push strobe.
  input  wire logic [31:0] tx_word_reg,
  output logic      [31:0] rx_buffer_word,
  output logic      [31:0] txl              // Last word pushed.
);
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      rx_buffer_word <= 32'h5a5a0000;
    else if (rx_pop_reg)
      rx_buffer_word <= rx_buffer_word + 32'h1;
  always_ff @(posedge clk_sys)
    if (tx_push_reg)
      txl <= tx_word_reg;
endmodule : shifr_rx_model

// [tb/shifr_regs_test.sv]
// Self-checking bench for the interrupt and buffer register bank.
`timescale 1ns/1ps
module shifr_regs_test;
  logic        clk_sys = 1'b0, rst_b = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1, transfer_start_bit = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_push_reg, rx_pop_reg, irq_reg;
  logic [7:0]  s_axi_awaddr = 8'h0;  // Shared by both address channels.
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rx_buffer_word, tx_word_reg, txl, rd;
  logic [23:0] flag_event = 24'h0, status_flags, words_remaining;
  logic [24:0] transfer_byte_length = 25'h0;
  int          n_errors = 0, check_count = 0;
  always #12.5 clk_sys = ~clk_sys;  // 40 MHz.
  shifr_regs u_shifr_regs (.clk_sys, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr(s_axi_awaddr), .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .flag_event, .transfer_byte_length, .transfer_start_bit, .rx_buffer_word,
    .tx_push_reg, .tx_word_reg, .rx_pop_reg, .status_flags, .words_remaining, .irq_reg);
  shifr_rx_model u_shifr_rx_model (.clk_sys, .rst_b, .rx_pop_reg, .tx_push_reg, .tx_word_reg, .rx_buffer_word, .txl);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    n_errors += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic end_sim(input int t);
    n_errors += t;
    $display("%0d checks, %0d errors", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // One whole-word access; a bus that never answers ends the run.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    for (int k = 0; k == 0 || !(w ? s_axi_bvalid : s_axi_rvalid); k++)
    begin
      @(posedge clk_sys);
      if (k > 40) end_sim(1);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rsp = w ? s_axi_bresp : s_axi_rresp;
  endtask : xfer
  task automatic t_irq();
    xfer(1'b1, 8'h3c, 32'h00800020);
    chk({30'h0, rsp}, {30'h0, shifr_pkg::RESP_OKAY});
    xfer(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h00800020);
    xfer(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h7c, 32'h0);
    chk({30'h0, rsp}, {30'h0, shifr_pkg::RESP_SLVERR});
    flag_event <= 24'hc087ff;  // Pulses on latching bits, a level on bit 15.
    @(posedge clk_sys);
    flag_event <= 24'h008000;
    repeat (3) @(posedge clk_sys);
    chk({status_flags, 7'h0, irq_reg}, 32'hc087ff01);
    xfer(1'b1, 8'h38, 32'h00c007fe);
    repeat (3) @(posedge clk_sys);
    chk({status_flags, 7'h0, irq_reg}, 32'h00800100);
    $display("irq test done");
  endtask : t_irq
  task automatic t_count();
    transfer_byte_length <= 25'h9;
    transfer_start_bit <= 1'b1;
    @(posedge clk_sys);
    transfer_start_bit <= 1'b0;
    xfer(1'b1, 8'hfc, 32'hcafe0001);
    chk({30'h0, rsp}, {30'h0, shifr_pkg::RESP_OKAY});
    xfer(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h5a5a0000);
    chk(txl, 32'hcafe0001);
    xfer(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({8'h0, words_remaining}, 32'h1);
    xfer(1'b0, 8'ha0, 32'h0);
    chk(rd, 32'h5a5a0001);
    xfer(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h5a5a0002);
    repeat (2) @(posedge clk_sys);
    chk({8'h0, words_remaining}, 32'h0);
    transfer_byte_length <= 25'h8;
    transfer_start_bit <= 1'b1;
    @(posedge clk_sys);
    transfer_start_bit <= 1'b0;
    @(posedge clk_sys);
    chk({8'h0, words_remaining}, 32'h2);
    $display("counter test done");
  endtask : t_count
  // Reset in mid-run clears flags, request, counter and the enable mask.
  task automatic t_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({status_flags, 7'h0, irq_reg}, 32'h0);
    chk({8'h0, words_remaining}, 32'h0);
    rst_b <= 1'b1;
    xfer(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_irq();
    t_count();
    t_reset();
    end_sim(0);
  end
endmodule : shifr_regs_test
